// ==== hdl/wdu_regs.vh ====
`ifndef WDU_REGS_VH
`define WDU_REGS_VH

// Register byte offsets.
`define WDU_OFS_CTRL 8'h00
`define WDU_OFS_CLEAR 8'h04
`define WDU_OFS_COUNT 8'h08
`define WDU_OFS_IRQ_STAT 8'h0c
`define WDU_OFS_IRQ_CLR 8'h10
`define WDU_OFS_IRQ_EN 8'h14
`define WDU_OFS_ID 8'h18

// Control word field positions.
`define WDU_CTRL_EN 0
`define WDU_CTRL_MODE 1
`define WDU_CTRL_PSEL_LO 8
`define WDU_CTRL_PSEL_HI 12
`define WDU_CTRL_BAN_LO 16
`define WDU_CTRL_BAN_HI 20

// Clear register key bit.
`define WDU_CLEAR_BIT 0

// Interrupt status bit positions.
`define WDU_IRQ_TIMEOUT 0
`define WDU_IRQ_LATE_CLEAR 1
`define WDU_IRQ_EARLY_CLEAR 2

// Reset values.
`define WDU_RST_CTRL 12'h000
`define WDU_RST_IRQ 3'h0

// Synchronizer timing counts.
`define WDU_SYNC_PCLK_CYCLES 2
`define WDU_SYNC_SRC_TICKS 2

`endif

// ==== hdl/wdu_sync.v ====
`default_nettype none

// Carries a freshly written control word into the watchdog tick domain.
module wdu_sync #(
   parameter DW = 12,
   parameter PCLK_CYCLES = 2,
   parameter SRC_TICKS = 2
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   input wire ce,
   // Launch and tick.
   input wire start,
   input wire [DW-1:0] wr_data,
   input wire tick,
   // Result.
   output reg busy,
   output reg [DW-1:0] q
);

   reg [DW-1:0] pend;
   reg [1:0] pcnt;
   reg [1:0] tcnt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         q <= {DW{1'b0}};
         pend <= {DW{1'b0}};
         pcnt <= 2'h0;
         tcnt <= 2'h0;
      end else if (ce) begin
         if (start) begin
            // A new write restarts the hand-over with the latest value.
            busy <= 1'b1;
            pend <= wr_data;
            pcnt <= 2'h0;
            tcnt <= 2'h0;
         end else if (busy) begin
            if (pcnt != PCLK_CYCLES[1:0]) begin
               pcnt <= pcnt + 2'h1;
            end
            if (tick && tcnt != SRC_TICKS[1:0]) begin
               tcnt <= tcnt + 2'h1;
            end
            // Commit after both bus cycles and source ticks have passed.
            if (pcnt == PCLK_CYCLES[1:0] && tcnt == SRC_TICKS[1:0]) begin
               q <= pend;
               busy <= 1'b0;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== hdl/wdu_top.v ====
// Operation
// - Clearing the counter in the second half of the timeout fires a reset at once.
// - Writing prescales, enable or mode starts a hand-over into the tick domain.
// - Only the enable bit shows hand-over progress; other fields show nothing.
// - Enable reads the old value until the hand-over completes; software polls.
//
// The APB slave port and the register offsets were left to the implementer.
`include "wdu_regs.vh"
`default_nettype none

module wdu_top #(
   parameter [31:0] ID_VALUE = 32'h0000_0a5a
) (
   // Clock, reset and enable.
   input wire pclk,
   input wire presetn,
   input wire ce,
   // APB slave.
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Watchdog source clock, sampled as a plain input.
   input wire wd_src_clk,
   // Outputs.
   output reg wd_reset,
   output reg irq
);

   // Period in source ticks for a prescale select: two to the power sel plus one.
   function [32:0] wdu_period;
      input [4:0] sel;
      begin
         if (sel > 5'd30) begin
            wdu_period = 33'h1_0000_0000;
         end else begin
            wdu_period = 33'h1 << (sel + 5'd1);
         end
      end
   endfunction

   // Packs the synchronized control fields: ban select, timeout select, mode, enable.
   function [11:0] wdu_pack_ctrl;
      input [31:0] d;
      begin
         wdu_pack_ctrl = {d[`WDU_CTRL_BAN_HI:`WDU_CTRL_BAN_LO],
            d[`WDU_CTRL_PSEL_HI:`WDU_CTRL_PSEL_LO], d[`WDU_CTRL_MODE], d[`WDU_CTRL_EN]};
      end
   endfunction

   reg src_meta;
   reg src_sync;
   reg src_prev;
   wire src_tick;

   reg [11:0] ctrl_wr;
   reg [31:0] count;
   reg [2:0] irq_stat;
   reg [2:0] irq_en;
   wire sync_busy;
   wire [11:0] ctrl_act;
   wire act_en;
   wire act_mode;
   wire [4:0] act_psel;
   wire [4:0] act_ban;
   wire [32:0] timeout_len;
   wire [32:0] ban_len;
   wire [32:0] count_ext;

   wire access;
   wire wr_en;
   wire rd_en;
   wire mapped;
   wire ctrl_write;
   wire clear_req;
   reg late_clear;
   reg early_clear;
   reg timed_out;
   reg [2:0] next_irq_stat;
   reg [31:0] next_rdata;

   // Source clock passes two flip-flops before any logic reads it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_meta <= 1'b0;
         src_sync <= 1'b0;
         src_prev <= 1'b0;
      end else if (ce) begin
         src_meta <= wd_src_clk;
         src_sync <= src_meta;
         src_prev <= src_sync;
      end
   end

   assign src_tick = src_sync & ~src_prev;

   // APB handshake: one wait state; writes land when pready is high, read data is captured in the wait cycle before it.
   assign access = psel & penable & pready;
   assign wr_en = access & pwrite;
   assign rd_en = psel & penable & ~pready & ~pwrite;
   assign mapped = (paddr == `WDU_OFS_CTRL) || (paddr == `WDU_OFS_CLEAR) ||
      (paddr == `WDU_OFS_COUNT) || (paddr == `WDU_OFS_IRQ_STAT) ||
      (paddr == `WDU_OFS_IRQ_CLR) || (paddr == `WDU_OFS_IRQ_EN) ||
      (paddr == `WDU_OFS_ID);
   assign ctrl_write = wr_en && paddr == `WDU_OFS_CTRL;
   assign clear_req = wr_en && paddr == `WDU_OFS_CLEAR && pwdata[`WDU_CLEAR_BIT];

   wdu_sync #(
      .DW(12),
      .PCLK_CYCLES(`WDU_SYNC_PCLK_CYCLES),
      .SRC_TICKS(`WDU_SYNC_SRC_TICKS)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(ctrl_write),
      .wr_data(wdu_pack_ctrl(pwdata)),
      .tick(src_tick),
      .busy(sync_busy),
      .q(ctrl_act)
   );

   assign act_en = ctrl_act[0];
   assign act_mode = ctrl_act[1];
   assign act_psel = ctrl_act[6:2];
   assign act_ban = ctrl_act[11:7];
   assign timeout_len = wdu_period(act_psel);
   assign ban_len = wdu_period(act_ban);
   assign count_ext = {1'b0, count};

   // Written control word as software last stored it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_wr <= `WDU_RST_CTRL;
      end else if (ce && ctrl_write) begin
         ctrl_wr <= wdu_pack_ctrl(pwdata);
      end
   end

   // Watchdog event decode.
   always @* begin
      late_clear = 1'b0;
      early_clear = 1'b0;
      timed_out = 1'b0;
      if (act_en) begin
         if (clear_req) begin
            if (count_ext >= (timeout_len >> 1)) begin
               late_clear = 1'b1;
            end else if (act_mode && count_ext < ban_len) begin
               early_clear = 1'b1;
            end
         end else if (src_tick && count_ext + 33'h1 >= timeout_len) begin
            timed_out = 1'b1;
         end
      end
   end

   // Tick counter, cleared by software, by a fired reset or while disabled.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 32'h0;
         wd_reset <= 1'b0;
      end else if (ce) begin
         wd_reset <= late_clear | early_clear | timed_out;
         if (!act_en || clear_req || timed_out) begin
            count <= 32'h0;
         end else if (src_tick) begin
            count <= count + 32'h1;
         end
      end
   end

   // Sticky status: a new event wins over a clear in the same cycle.
   always @* begin
      next_irq_stat = irq_stat;
      if (wr_en && paddr == `WDU_OFS_IRQ_CLR) begin
         next_irq_stat = irq_stat & ~pwdata[2:0];
      end
      next_irq_stat[`WDU_IRQ_TIMEOUT] = next_irq_stat[`WDU_IRQ_TIMEOUT] | timed_out;
      next_irq_stat[`WDU_IRQ_LATE_CLEAR] = next_irq_stat[`WDU_IRQ_LATE_CLEAR] | late_clear;
      next_irq_stat[`WDU_IRQ_EARLY_CLEAR] = next_irq_stat[`WDU_IRQ_EARLY_CLEAR] | early_clear;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= `WDU_RST_IRQ;
         irq_en <= `WDU_RST_IRQ;
         irq <= 1'b0;
      end else if (ce) begin
         irq_stat <= next_irq_stat;
         if (wr_en && paddr == `WDU_OFS_IRQ_EN) begin
            irq_en <= pwdata[2:0];
         end
         irq <= |(next_irq_stat & irq_en);
      end
   end

   // Read mux: enable shows the committed value, other fields the written one.
   always @* begin
      next_rdata = 32'h0;
      case (paddr)
         `WDU_OFS_CTRL: begin
            next_rdata[`WDU_CTRL_EN] = act_en;
            next_rdata[`WDU_CTRL_MODE] = ctrl_wr[1];
            next_rdata[`WDU_CTRL_PSEL_HI:`WDU_CTRL_PSEL_LO] = ctrl_wr[6:2];
            next_rdata[`WDU_CTRL_BAN_HI:`WDU_CTRL_BAN_LO] = ctrl_wr[11:7];
         end
         `WDU_OFS_COUNT: begin
            next_rdata = count;
         end
         `WDU_OFS_IRQ_STAT: begin
            next_rdata[2:0] = irq_stat;
         end
         `WDU_OFS_IRQ_EN: begin
            next_rdata[2:0] = irq_en;
         end
         `WDU_OFS_ID: begin
            next_rdata = ID_VALUE;
         end
         default: begin
            next_rdata = 32'h0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (rd_en) begin
            prdata <= next_rdata;
         end
      end
   end

endmodule

`default_nettype wire

// ==== dv/wdu_top_sva.sv ====
`default_nettype none
module wdu_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wd_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_wait_state: assert property (psel && penable && !$past(penable) |=> pready)
      else $error("pready not one cycle after access start");
   a_ready_needs_req: assert property (pready |-> psel && penable)
      else $error("pready without a request");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside an answer");
   a_reset_one_pulse: assert property (wd_reset |=> !wd_reset)
      else $error("watchdog reset longer than one cycle");
endmodule
`default_nettype wire

// ==== dv/wdu_top_bench.sv ====
`include "wdu_regs.vh"
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module wdu_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary identity value.
   localparam [31:0] ID = 32'h0000_1234;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic src = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic wd_reset;
   logic irq;
   logic err;
   logic [3:0] div = 4'h0;
   int miscompares = 0;
   int num_checks = 0;
   int resets = 0;
   int base;
   initial forever #4 pclk = ~pclk;
   // Source clock at one eighth of the bus clock; counts reset pulses.
   always @(posedge pclk) begin
      div <= div + 4'h1;
      src <= div[2];
      if (wd_reset === 1'b1) begin
         resets <= resets + 1;
      end
   end
   wdu_top #(.ID_VALUE(ID)) u_wdu_top (
      .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wd_src_clk(src), .wd_reset(wd_reset), .irq(irq)
   );
   task print_verdict;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         miscompares++;
         print_verdict();
      end
   endtask
   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      for (n = 0; n < 300; n++) begin
         apb(1'b0, a, 32'h0);
         if ((rd & m) === e) break;
      end
      `CHK(rd & m, e)
      if (n == 300) begin
         print_verdict();
      end
   endtask
   task t_reset_regs;
      apb(1'b0, `WDU_OFS_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, `WDU_OFS_ID, 32'hffff_ffff);
      apb(1'b0, `WDU_OFS_ID, 32'h0);
      `CHK(rd, ID)
      apb(1'b0, 8'h1c, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
   endtask
   task t_enable;
      apb(1'b1, `WDU_OFS_CTRL, 32'h0000_0201);
      apb(1'b0, `WDU_OFS_CTRL, 32'h0);
      `CHK(rd, 32'h0000_0200)
      poll(`WDU_OFS_CTRL, 32'hffff_ffff, 32'h0000_0201);
      apb(1'b1, `WDU_OFS_CLEAR, 32'h1);
      apb(1'b1, `WDU_OFS_IRQ_EN, 32'h2);
   endtask
   task t_late_clear;
      `CHK(resets, 0)
      poll(`WDU_OFS_COUNT, 32'hffff_ffff, 32'h4);
      base = resets;
      apb(1'b1, `WDU_OFS_CLEAR, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK(resets, base + 1)
      `CHK(irq, 1'b1)
      apb(1'b1, `WDU_OFS_IRQ_CLR, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      poll(`WDU_OFS_IRQ_STAT, 32'h7, 32'h1);
      `CHK(irq, 1'b0)
   endtask
   task t_early_clear;
      apb(1'b1, `WDU_OFS_CTRL, 32'h0);
      poll(`WDU_OFS_CTRL, 32'h1, 32'h0);
      apb(1'b0, `WDU_OFS_COUNT, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, `WDU_OFS_IRQ_CLR, 32'h7);
      apb(1'b1, `WDU_OFS_IRQ_EN, 32'h4);
      apb(1'b1, `WDU_OFS_CTRL, 32'h0001_0303);
      poll(`WDU_OFS_CTRL, 32'hffff_ffff, 32'h0001_0303);
      base = resets;
      apb(1'b1, `WDU_OFS_CLEAR, 32'h1);
      repeat (2) @(posedge pclk);
      `CHK(resets, base + 1)
      `CHK(irq, 1'b1)
      apb(1'b0, `WDU_OFS_IRQ_STAT, 32'h0);
      `CHK(rd, 32'h4)
   endtask
   task t_freeze;
      apb(1'b0, `WDU_OFS_COUNT, 32'h0);
      base = rd;
      ce <= 1'b0;
      repeat (64) @(posedge pclk);
      ce <= 1'b1;
      apb(1'b0, `WDU_OFS_COUNT, 32'h0);
      `CHK(rd - base < 3, 1'b1)
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_regs();
      t_enable();
      t_late_clear();
      t_early_clear();
      t_freeze();
      print_verdict();
   end
endmodule
bind wdu_top wdu_top_sva u_wdu_top_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .wd_reset(wd_reset)
);
`default_nettype wire
